// File: logic/ldsc_regs.sv
// ldsc_regs: legacy display retrace status, feature control and misc output.
// assumes host strobes are one cycle and never overlap; blanking levels
// come from other clock domains and are synchronised here.
//
// Operation
// (R1) status bits 2:1 always read zero
// (R2) status bit 0 set during any retrace
// (R3) status bit 0 clear during active display
// (R4) legacy disabled: retrace taken from assigned pipe
// (R5) feature write at status port, read 3CAh
// (R6) feature bits 7:4 and 2:0 read zero
// (R7) feature bit 3 plain storage, no effect
// (R8) misc written 3C2h, read 3CCh, reset 00h
// (R9) misc bit 7: vsync polarity in native mode
// (R10) misc polarities only in native mode, else port
// (R11) status port address chosen by emulation mode
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
module ldsc_regs (
	// clock and reset
	input logic core_clk,
	input logic rst,
	// host register port
	input logic [ldsc_pkg::ADDR_W-1:0] addr,
	input logic [ldsc_pkg::DATA_W-1:0] wdata,
	input logic wr,
	input logic rd,
	output logic [ldsc_pkg::DATA_W-1:0] rdata,
	// timing sources
	input logic legacy_enable,
	input logic legacy_hblank,
	input logic legacy_vblank,
	input logic pipe_hblank,
	input logic pipe_vblank,
	// sync polarity
	input logic legacy_native,
	input logic port_hsync_neg,
	input logic port_vsync_neg,
	output logic hsync_neg,
	output logic vsync_neg,
	output logic colour_emulation
);
	import ldsc_pkg::*;

	// ==========================================================
	// address decode helper
	function automatic logic is_status_addr(input logic [ADDR_W-1:0] a, input logic colour);
		logic [ADDR_W-1:0] want;
		want = colour ? STAT_COLOUR_ADDR : STAT_MONO_ADDR;
		is_status_addr = (a == want);
	endfunction : is_status_addr

	// ==========================================================
	// synchronised blanking levels
	logic [3:0] blank_s;
	logic leg_h;
	logic leg_v;
	logic pipe_h;
	logic pipe_v;
	logic sel_h;
	logic sel_v;

	ldsc_sync #(
		.WIDTH(4)
	) u_sync (
		.core_clk(core_clk),
		.rst(rst),
		.async_in({pipe_vblank, pipe_hblank, legacy_vblank, legacy_hblank}),
		.sync_out(blank_s)
	);

	assign leg_h = blank_s[0];
	assign leg_v = blank_s[1];
	assign pipe_h = blank_s[2];
	assign pipe_v = blank_s[3];

	// status keeps running from the pipe when the legacy engine is off
	always_comb
	begin
		sel_h = legacy_enable ? leg_h : pipe_h; // [R4]
		sel_v = legacy_enable ? leg_v : pipe_v; // [R4]
	end

	// ==========================================================
	// registers
	logic [DATA_W-1:0] misc_output_control;
	logic [DATA_W-1:0] feature_control;
	logic [DATA_W-1:0] next_misc;
	logic [DATA_W-1:0] next_feature;
	logic [DATA_W-1:0] next_rdata;
	logic [DATA_W-1:0] retrace_status;
	logic next_hsync_neg;
	logic next_vsync_neg;
	logic next_colour;
	logic colour_sel;

	assign colour_sel = misc_output_control[MISC_COLOUR_BIT];

	always_comb
	begin
		retrace_status = '0; // [R1]
		retrace_status[STAT_BLANK_BIT] = sel_h | sel_v; // [R2] [R3]
		retrace_status[STAT_VRETRACE_BIT] = sel_v;
	end

	always_comb
	begin
		next_misc = misc_output_control;
		next_feature = feature_control;
		if (wr && addr == MISC_WR_ADDR)
		begin
			next_misc = wdata; // [R8]
		end
		else if (wr && is_status_addr(addr, colour_sel))
		begin
			// only bit 3 is storage; the connector bits are absent
			next_feature = wdata & FEAT_WR_MASK; // [R5] [R6] [R7]
		end
	end

	// read data lives for exactly one cycle; zero otherwise
	always_comb
	begin
		next_rdata = RDATA_RESET;
		if (rd && addr == MISC_RD_ADDR)
		begin
			next_rdata = misc_output_control; // [R8]
		end
		else if (rd && addr == FEAT_RD_ADDR)
		begin
			next_rdata = feature_control; // [R5]
		end
		else if (rd && is_status_addr(addr, colour_sel))
		begin
			next_rdata = retrace_status; // [R11]
		end
	end

	// feature bit 3 feeds nothing here by design
	always_comb
	begin
		next_colour = colour_sel;
		if (legacy_native)
		begin
			next_hsync_neg = misc_output_control[MISC_HPOL_BIT]; // [R10]
			next_vsync_neg = misc_output_control[MISC_VPOL_BIT]; // [R9] [R10]
		end
		else
		begin
			next_hsync_neg = port_hsync_neg; // [R10]
			next_vsync_neg = port_vsync_neg; // [R10]
		end
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			misc_output_control <= MISC_RESET;
			feature_control <= FEAT_RESET;
			rdata <= RDATA_RESET;
			hsync_neg <= 1'b0;
			vsync_neg <= 1'b0;
			colour_emulation <= 1'b0;
		end
		else
		begin
			misc_output_control <= next_misc;
			feature_control <= next_feature;
			rdata <= next_rdata;
			hsync_neg <= next_hsync_neg;
			vsync_neg <= next_vsync_neg;
			colour_emulation <= next_colour;
		end
	end

	// ==========================================================
	// assertions
	property p_stat_zero;
		@(posedge core_clk) disable iff (rst)
		(rd && is_status_addr(addr, colour_sel)) |=> (rdata[2:1] == 2'h0);
	endproperty
	a_stat_zero: assert property (p_stat_zero) // [R1]
		else $error("status bits 2:1 not zero");

	property p_blank_set;
		@(posedge core_clk) disable iff (rst)
		(rd && is_status_addr(addr, colour_sel) && (sel_h || sel_v)) |=> rdata[0];
	endproperty
	a_blank_set: assert property (p_blank_set) // [R2]
		else $error("status bit 0 clear during retrace");

	property p_blank_clear;
		@(posedge core_clk) disable iff (rst)
		(rd && is_status_addr(addr, colour_sel) && !sel_h && !sel_v) |=> !rdata[0];
	endproperty
	a_blank_clear: assert property (p_blank_clear) // [R3]
		else $error("status bit 0 set during active display");

	property p_pipe_src;
		@(posedge core_clk) disable iff (rst)
		(!legacy_enable && rd && is_status_addr(addr, colour_sel))
			|=> (rdata[0] == $past(pipe_h | pipe_v) && rdata[3] == $past(pipe_v));
	endproperty
	a_pipe_src: assert property (p_pipe_src) // [R4]
		else $error("status not taken from pipe");

	property p_feat_wr;
		@(posedge core_clk) disable iff (rst)
		(wr && addr != MISC_WR_ADDR && is_status_addr(addr, colour_sel))
			##1 (rd && addr == FEAT_RD_ADDR)
			|=> (rdata == ($past(wdata, 2) & FEAT_WR_MASK));
	endproperty
	a_feat_wr: assert property (p_feat_wr) // [R5]
		else $error("feature write not read back at 3CAh");

	property p_feat_zero;
		@(posedge core_clk) disable iff (rst)
		(rd && addr == FEAT_RD_ADDR) |=> (rdata[7:4] == 4'h0 && rdata[2:0] == 3'h0);
	endproperty
	a_feat_zero: assert property (p_feat_zero) // [R6]
		else $error("feature reserved bits not zero");

	property p_feat_keep;
		@(posedge core_clk) disable iff (rst)
		!(wr && is_status_addr(addr, colour_sel)) |=> $stable(feature_control);
	endproperty
	a_feat_keep: assert property (p_feat_keep) // [R7]
		else $error("feature bit changed without write");

	property p_misc_rw;
		@(posedge core_clk) disable iff (rst)
		(wr && addr == MISC_WR_ADDR) ##1 (rd && addr == MISC_RD_ADDR)
			|=> (rdata == $past(wdata, 2));
	endproperty
	a_misc_rw: assert property (p_misc_rw) // [R8]
		else $error("misc write not read back at 3CCh");

	property p_vpol_native;
		@(posedge core_clk) disable iff (rst)
		legacy_native |=> (vsync_neg == $past(misc_output_control[MISC_VPOL_BIT]));
	endproperty
	a_vpol_native: assert property (p_vpol_native) // [R9]
		else $error("native vsync polarity wrong");

	property p_pol_port;
		@(posedge core_clk) disable iff (rst)
		!legacy_native |=> (vsync_neg == $past(port_vsync_neg)
			&& hsync_neg == $past(port_hsync_neg));
	endproperty
	a_pol_port: assert property (p_pol_port) // [R10]
		else $error("port polarity not applied");

	property p_stat_other;
		@(posedge core_clk) disable iff (rst)
		(rd && addr == (colour_sel ? STAT_MONO_ADDR : STAT_COLOUR_ADDR)) |=> (rdata == 8'h00);
	endproperty
	a_stat_other: assert property (p_stat_other) // [R11]
		else $error("status answered at wrong emulation port");

	property p_rdata_idle;
		@(posedge core_clk) disable iff (rst)
		!rd |=> (rdata == RDATA_RESET);
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) // [R8]
		else $error("read data not idle outside answer cycle");

	property p_misc_wr;
		@(posedge core_clk) disable iff (rst)
		(wr && addr == MISC_WR_ADDR) |=> (misc_output_control == $past(wdata));
	endproperty
	a_misc_wr: assert property (p_misc_wr) // [R8]
		else $error("misc write not stored");

	property p_misc_keep;
		@(posedge core_clk) disable iff (rst)
		!(wr && addr == MISC_WR_ADDR) |=> $stable(misc_output_control);
	endproperty
	a_misc_keep: assert property (p_misc_keep) // [R8]
		else $error("misc changed without write");

	property p_hpol_native;
		@(posedge core_clk) disable iff (rst)
		legacy_native |=> (hsync_neg == $past(misc_output_control[MISC_HPOL_BIT]));
	endproperty
	a_hpol_native: assert property (p_hpol_native) // [R10]
		else $error("native hsync polarity wrong");

	property p_vert_bit;
		@(posedge core_clk) disable iff (rst)
		(rd && is_status_addr(addr, colour_sel)) |=> (rdata[STAT_VRETRACE_BIT] == $past(sel_v));
	endproperty
	a_vert_bit: assert property (p_vert_bit) // [R4]
		else $error("vertical retrace bit not from selected source");

	property p_colour_copy;
		@(posedge core_clk) disable iff (rst)
		!rst |=> (colour_emulation == $past(colour_sel));
	endproperty
	a_colour_copy: assert property (p_colour_copy) // [R11]
		else $error("emulation select output lags misc");

	property p_feat_store;
		@(posedge core_clk) disable iff (rst)
		(wr && addr != MISC_WR_ADDR && is_status_addr(addr, colour_sel))
			|=> (feature_control[FEAT_KEEP_BIT] == $past(wdata[FEAT_KEEP_BIT]));
	endproperty
	a_feat_store: assert property (p_feat_store) // [R7]
		else $error("feature bit 3 not stored");

endmodule : ldsc_regs

// File: logic/ldsc_pkg.sv
// ldsc_pkg: constants for the legacy display status and control registers.
// assumes an 8-bit host port with 16-bit legacy i/o addresses.
package ldsc_pkg;

	// ==========================================================
	// port widths
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;

	// ==========================================================
	// i/o addresses
	localparam logic [15:0] MISC_WR_ADDR = 16'h03C2;
	localparam logic [15:0] MISC_RD_ADDR = 16'h03CC;
	localparam logic [15:0] FEAT_RD_ADDR = 16'h03CA;
	localparam logic [15:0] STAT_MONO_ADDR = 16'h03BA;
	localparam logic [15:0] STAT_COLOUR_ADDR = 16'h03DA;

	// ==========================================================
	// reset values
	localparam logic [7:0] MISC_RESET = 8'h00;
	localparam logic [7:0] FEAT_RESET = 8'h00;
	localparam logic [7:0] RDATA_RESET = 8'h00;

	// ==========================================================
	// field positions
	localparam int MISC_COLOUR_BIT = 0;
	localparam int MISC_HPOL_BIT = 6;
	localparam int MISC_VPOL_BIT = 7;
	localparam int FEAT_KEEP_BIT = 3;
	localparam logic [7:0] FEAT_WR_MASK = 8'h08;
	localparam int STAT_BLANK_BIT = 0;
	localparam int STAT_VRETRACE_BIT = 3;

	// ==========================================================
	// synchroniser depth
	localparam int SYNC_STAGES = 2;

endpackage : ldsc_pkg

// File: logic/ldsc_sync.sv
// ldsc_sync: two-flop synchroniser for a bundle of independent levels.
// assumes each bit is a slow level; multi-bit words are not kept coherent.
`timescale 1ns/1ps
module ldsc_sync #(
	parameter int WIDTH = 4
) (
	// clock and reset
	input logic core_clk,
	input logic rst,
	// levels
	input logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	import ldsc_pkg::*;

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] next_stage1;
	logic [WIDTH-1:0] next_sync_out;

	// ==========================================================
	// next values
	always_comb
	begin
		next_stage1 = async_in;
		// first stage feeds only the second
		next_sync_out = stage1;
	end

	// ==========================================================
	// registers
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			stage1 <= '0;
			sync_out <= '0;
		end
		else
		begin
			stage1 <= next_stage1;
			sync_out <= next_sync_out;
		end
	end

endmodule : ldsc_sync

// File: testbench/ldsc_regs_tb_top.sv
// ldsc_regs_tb_top: self-checking bench for the legacy display status and control registers.
// assumes reads answer in the one cycle after the read strobe and nowhere else.
`timescale 1ns/1ps
module ldsc_regs_tb_top;
	import ldsc_pkg::*;

	// ==========================================================
	// stimulus and observed signals
	logic core_clk = 1'h0;
	logic rst = 1'h1;
	logic wr = 1'h0;
	logic rd = 1'h0;
	logic rd_q = 1'h0;
	logic [15:0] addr = 16'h0000;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic legacy_enable = 1'h1;
	logic legacy_hblank = 1'h0;
	logic legacy_vblank = 1'h0;
	logic pipe_hblank = 1'h0;
	logic pipe_vblank = 1'h0;
	logic legacy_native = 1'h0;
	logic port_hsync_neg = 1'h0;
	logic port_vsync_neg = 1'h0;
	logic hsync_neg;
	logic vsync_neg;
	logic colour_emulation;
	logic [31:0] seed = 32'h00000042;
	logic [7:0] exp_q[$];
	int n_fail = 0;
	int samples_checked = 0;

	ldsc_regs uut (
		.core_clk(core_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .legacy_enable(legacy_enable), .legacy_hblank(legacy_hblank),
		.legacy_vblank(legacy_vblank), .pipe_hblank(pipe_hblank), .pipe_vblank(pipe_vblank),
		.legacy_native(legacy_native), .port_hsync_neg(port_hsync_neg),
		.port_vsync_neg(port_vsync_neg), .hsync_neg(hsync_neg), .vsync_neg(vsync_neg),
		.colour_emulation(colour_emulation)
	);

	initial
	begin
		forever #25 core_clk = ~core_clk;
	end

	// ==========================================================
	// helpers
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction : xs

	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			$display("BAD %s expected %h seen %h", name, exp, seen);
			n_fail++;
		end
	endtask : chk

	task automatic wr_t(input logic [15:0] a, input logic [7:0] d);
		@(posedge core_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge core_clk);
		wr <= 1'h0;
	endtask : wr_t

	task automatic rd_t(input logic [15:0] a, input logic [7:0] e);
		@(posedge core_clk);
		addr <= a;
		rd <= 1'h1;
		exp_q.push_back(e);
		@(posedge core_clk);
		rd <= 1'h0;
	endtask : rd_t

	// write then read back with no idle cycle between the strobes
	task automatic wr_rd_t(input logic [15:0] wa, input logic [7:0] d, input logic [15:0] ra,
		input logic [7:0] e);
		@(posedge core_clk);
		addr <= wa;
		wdata <= d;
		wr <= 1'h1;
		@(posedge core_clk);
		wr <= 1'h0;
		addr <= ra;
		rd <= 1'h1;
		exp_q.push_back(e);
		@(posedge core_clk);
		rd <= 1'h0;
	endtask : wr_rd_t

	task automatic final_report;
		$display("checked %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : final_report

	// ==========================================================
	// read data monitor: outside the answer cycle rdata must idle at zero
	always @(posedge core_clk)
		rd_q <= rd;

	always @(negedge core_clk)
	begin
		if (!rd_q)
			chk("idle rdata", rdata, RDATA_RESET);
		else if (exp_q.size() == 0)
		begin
			$display("BAD rdata expected none seen %h", rdata);
			n_fail++;
		end
		else
			chk("rdata", rdata, exp_q.pop_front());
	end

	// ==========================================================
	// watchdog: the sequence needs well under 1000 cycles
	initial
	begin
		#150000;
		n_fail++;
		final_report;
	end

	// ==========================================================
	// main sequence
	initial
	begin
		logic [7:0] d;
		logic h;
		logic v;
		logic e;
		repeat (3) @(posedge core_clk);
		rst <= 1'h0;
		rd_t(16'h03CC, 8'h00);
		rd_t(16'h03CA, 8'h00);
		wr_rd_t(16'h03BA, 8'hFF, 16'h03CA, 8'h08);
		wr_t(16'h03DA, 8'h00);
		rd_t(16'h03CA, 8'h08);
		rd_t(16'h1234, 8'h00);
		// random misc values with random mode and port polarity
		for (int i = 0; i < 16; i++)
		begin
			seed = xs(seed);
			d = seed[7:0];
			@(posedge core_clk);
			legacy_native <= seed[8];
			port_hsync_neg <= seed[9];
			port_vsync_neg <= seed[10];
			wr_rd_t(16'h03C2, d, 16'h03CC, d);
			@(negedge core_clk);
			chk("vsync_neg", {7'h00, vsync_neg}, {7'h00, seed[8] ? d[7] : seed[10]});
			chk("hsync_neg", {7'h00, hsync_neg}, {7'h00, seed[8] ? d[6] : seed[9]});
			chk("colour_emulation", {7'h00, colour_emulation}, {7'h00, d[0]});
		end
		// colour emulation moves the status and feature write port
		wr_t(16'h03C2, 8'h01);
		wr_t(16'h03DA, 8'hF7);
		rd_t(16'h03CA, 8'h00);
		// legacy source and pipe source disagree so the wrong pick shows
		for (int i = 0; i < 8; i++)
		begin
			h = i[0];
			v = i[1];
			e = i[2];
			@(posedge core_clk);
			legacy_enable <= e;
			legacy_hblank <= e ? h : ~h;
			legacy_vblank <= e ? v : ~v;
			pipe_hblank <= e ? ~h : h;
			pipe_vblank <= e ? ~v : v;
			repeat (3) @(posedge core_clk);
			rd_t(16'h03DA, {4'h0, v, 2'h0, h | v});
		end
		rd_t(16'h03BA, 8'h00);
		repeat (2) @(posedge core_clk);
		final_report;
	end

endmodule : ldsc_regs_tb_top
